// *** inc/csc_consts.svh ***
// Offsets, field positions, masks, reset values and counts of the
// capacitive sense control block.
// Assumes inclusion by bare name from the package and the design files.
`ifndef CSC_CONSTS_SVH
`define CSC_CONSTS_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define CSC_ADDR_CTRL0 8'h00
`define CSC_ADDR_CHAN 8'h01
`define CSC_ADDR_COUPLE 8'h02
`define CSC_ADDR_T0 8'h03
`define CSC_ADDR_T1L 8'h04
`define CSC_ADDR_T1H 8'h05

// ----------------------------------------------------------------------
// Control register 0 fields
// ----------------------------------------------------------------------
`define CSC_B_ENABLE 7
`define CSC_B_RANGE 6
`define CSC_B_CUR_HI 3
`define CSC_B_CUR_LO 2
`define CSC_B_DIR 1
`define CSC_B_EXTSEL 0
`define CSC_CTRL0_WMASK 8'hcd

// ----------------------------------------------------------------------
// Channel select and timer coupling fields
// ----------------------------------------------------------------------
`define CSC_CHAN_WMASK 8'h1f
`define CSC_CHAN_HI 4
`define CSC_B_T0CS 0
`define CSC_B_T1ON 1
`define CSC_B_T1GE 2
`define CSC_B_T1CS_LO 4
`define CSC_B_T1CS_HI 5
`define CSC_COUPLE_WMASK 8'h37

// ----------------------------------------------------------------------
// Codes, reset values and counts
// ----------------------------------------------------------------------
`define CSC_RESET_VAL 8'h00
`define CSC_CUR_OFF 2'h0
`define CSC_T1SRC_ICLK 2'h0
`define CSC_T1SRC_SYSCLK 2'h1
`define CSC_T1SRC_NONE 2'h2
`define CSC_T1SRC_OSC 2'h3
`define CSC_CHAN_MAX 5'h10
`define CSC_NUM_CHAN 17
`define CSC_ICLK_LAST 2'h3
`define CSC_T0_WIDTH 8
`define CSC_T1_WIDTH 16

`endif

// *** inc/csc_pkg.sv ***
// Types shared by the capacitive sense control block.
// Assumes csc_consts.svh is on the include path.
`include "csc_consts.svh"

package csc_pkg;

  // ----------------------------------------------------------------------
  // Oscillator and reference steering handed to the analog side
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic enable;
    logic high_range;
    logic [1:0] current;
    logic run;
    logic drive;
  } csc_osc_ctrl_t;

  // ----------------------------------------------------------------------
  // Software visible control storage
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [7:0] ctrl0;
    logic [7:0] chan;
    logic [7:0] couple;
  } csc_regs_t;

  // ----------------------------------------------------------------------
  // Whole state of the top module
  // ----------------------------------------------------------------------
  typedef struct packed {
    csc_regs_t regs;
    logic [7:0] rdata;
    logic [1:0] div;
    csc_osc_ctrl_t osc_ctrl;
    logic [`CSC_NUM_CHAN-1:0] chan_onehot;
    logic direction;
  } csc_state_t;

endpackage

// *** verilog/csc_sync.sv ***
// Three stage synchroniser with agreement filter and rising edge pulse.
// Assumes asynchronous inputs; one clock, synchronous active high reset.
`timescale 1ns/1ps

module csc_sync
  import csc_pkg::*;
#(
  parameter int WIDTH = 1
) (
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_level,
  output logic [WIDTH-1:0] o_rise
);

  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] level;
    logic [WIDTH-1:0] rise;
  } csc_sync_state_t;

  csc_sync_state_t st_ff;
  csc_sync_state_t nxt_st;
  logic [WIDTH-1:0] agree;

  // ----------------------------------------------------------------------
  // Filter
  // ----------------------------------------------------------------------
  // The first stage feeds only the second; the level follows once stages
  // two and three agree, so a metastable settle never counts twice.
  always_comb begin
    agree = ~(st_ff.s2 ^ st_ff.s3);
    nxt_st = st_ff;
    nxt_st.s1 = i_async;
    nxt_st.s2 = st_ff.s1;
    nxt_st.s3 = st_ff.s2;
    nxt_st.level = (agree & st_ff.s2) | (~agree & st_ff.level);
    nxt_st.rise = nxt_st.level & ~st_ff.level;
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign o_level = st_ff.level;
  assign o_rise = st_ff.rise;

endmodule

// *** verilog/csc_counter.sv ***
// Up counter with software load and a one cycle overflow pulse.
// Assumes increment and load come from logic on the same clock.
`timescale 1ns/1ps

module csc_counter
  import csc_pkg::*;
#(
  parameter int WIDTH = 16
) (
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  input wire logic i_inc,
  input wire logic i_load,
  input wire logic [WIDTH-1:0] i_load_data,
  output logic [WIDTH-1:0] o_count,
  output logic o_overflow
);

  typedef struct packed {
    logic [WIDTH-1:0] count;
    logic ovf;
  } csc_cnt_state_t;

  csc_cnt_state_t st_ff;
  csc_cnt_state_t nxt_st;

  // ----------------------------------------------------------------------
  // Count
  // ----------------------------------------------------------------------
  // A software load wins over a count in the same cycle, so a clear at the
  // start of a window is exact.
  always_comb begin
    nxt_st = st_ff;
    nxt_st.ovf = 1'b0;
    if (i_load) begin
      nxt_st.count = i_load_data;
    end else if (i_inc) begin
      nxt_st.count = st_ff.count + {{(WIDTH-1){1'b0}}, 1'b1};
      nxt_st.ovf = &st_ff.count;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign o_count = st_ff.count;
  assign o_overflow = st_ff.ovf;

endmodule

// *** verilog/csc_top.sv ***
// Capacitive sense control: registers, channel steering, oscillator
// control and coupling of the sensing oscillator into two timers.
// Assumes the oscillator output and the timer clock pin are asynchronous,
// while sleep and the gate input come from logic on i_ref_clk.
//
// Added by the designer: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps

`include "csc_consts.svh"

module csc_top
  import csc_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wr_data,
  input wire logic i_wr_en,
  input wire logic i_rd_en,
  input wire logic i_osc_out,
  input wire logic i_first_timer_clock_pin,
  input wire logic i_second_timer_gate,
  input wire logic i_sleep,
  output logic [7:0] o_rd_data,
  output csc_osc_ctrl_t o_osc_ctrl,
  output logic [`CSC_NUM_CHAN-1:0] o_sense_pin_sel,
  output logic o_first_timer_overflow,
  output logic o_second_timer_overflow
);

  csc_state_t st_ff;
  csc_state_t nxt_st;

  logic [1:0] sync_level;
  logic [1:0] sync_rise;
  logic osc_level;
  logic osc_rise;
  logic pin_rise;

  logic iclk_tick;
  logic osc_tick;
  logic t0_inc;
  logic t1_inc;
  logic t1_run;
  logic t0_load;
  logic t1_load;
  logic [`CSC_T0_WIDTH-1:0] t0_load_data;
  logic [`CSC_T1_WIDTH-1:0] t1_load_data;
  logic [`CSC_T0_WIDTH-1:0] t0_count;
  logic [`CSC_T1_WIDTH-1:0] t1_count;

  logic enable;
  logic [1:0] t1_src;

  // ----------------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------------
  csc_sync #(
    .WIDTH(2)
  ) u_sync (
    .i_ref_clk(i_ref_clk),
    .i_sys_rst(i_sys_rst),
    .i_async({i_first_timer_clock_pin, i_osc_out}),
    .o_level(sync_level),
    .o_rise(sync_rise)
  );

  assign osc_level = sync_level[0];
  assign osc_rise = sync_rise[0];
  assign pin_rise = sync_rise[1];

  // ----------------------------------------------------------------------
  // Clock selection into the timers
  // ----------------------------------------------------------------------
  assign enable = st_ff.regs.ctrl0[`CSC_B_ENABLE];
  assign t1_src = st_ff.regs.couple[`CSC_B_T1CS_HI:`CSC_B_T1CS_LO];

  // The instruction clock is the core clock divided by four, and it stops in sleep
  assign iclk_tick = (st_ff.div == `CSC_ICLK_LAST) && !i_sleep;

  // One oscillator period is one rising edge of the synced level
  assign osc_tick = osc_rise && enable;

  always_comb begin
    t0_inc = 1'b0;
    if (!st_ff.regs.couple[`CSC_B_T0CS]) begin
      t0_inc = iclk_tick;
    end else if (st_ff.regs.ctrl0[`CSC_B_EXTSEL]) begin
      t0_inc = osc_tick && !i_sleep;
    end else begin
      t0_inc = pin_rise && !i_sleep;
    end
  end

  // Gate is a same-clock level; a toggle built from the first timer's
  // overflow may drive it from outside.
  assign t1_run = st_ff.regs.couple[`CSC_B_T1ON] &&
    (!st_ff.regs.couple[`CSC_B_T1GE] || i_second_timer_gate);

  always_comb begin
    t1_inc = 1'b0;
    unique case (t1_src)
      `CSC_T1SRC_ICLK: t1_inc = iclk_tick;
      `CSC_T1SRC_SYSCLK: t1_inc = 1'b1;
      `CSC_T1SRC_NONE: t1_inc = 1'b0;
      `CSC_T1SRC_OSC: t1_inc = osc_tick;
    endcase
    t1_inc = t1_inc && t1_run;
  end

  // ----------------------------------------------------------------------
  // Software access to the timer counts
  // ----------------------------------------------------------------------
  // Writing a count lets software clear it at window start; reading it
  // captures the window result.
  assign t0_load = i_wr_en && (i_addr == `CSC_ADDR_T0);
  assign t0_load_data = i_wr_data;

  always_comb begin
    t1_load = 1'b0;
    t1_load_data = t1_count;
    if (i_wr_en && (i_addr == `CSC_ADDR_T1L)) begin
      t1_load = 1'b1;
      t1_load_data = {t1_count[15:8], i_wr_data};
    end else if (i_wr_en && (i_addr == `CSC_ADDR_T1H)) begin
      t1_load = 1'b1;
      t1_load_data = {i_wr_data, t1_count[7:0]};
    end
  end

  csc_counter #(
    .WIDTH(`CSC_T0_WIDTH)
  ) u_first_timer (
    .i_ref_clk(i_ref_clk),
    .i_sys_rst(i_sys_rst),
    .i_inc(t0_inc),
    .i_load(t0_load),
    .i_load_data(t0_load_data),
    .o_count(t0_count),
    .o_overflow(o_first_timer_overflow)
  );

  csc_counter #(
    .WIDTH(`CSC_T1_WIDTH)
  ) u_second_timer (
    .i_ref_clk(i_ref_clk),
    .i_sys_rst(i_sys_rst),
    .i_inc(t1_inc),
    .i_load(t1_load),
    .i_load_data(t1_load_data),
    .o_count(t1_count),
    .o_overflow(o_second_timer_overflow)
  );

  // ----------------------------------------------------------------------
  // Register file, steering and next state
  // ----------------------------------------------------------------------
  always_comb begin
    logic [7:0] wmasked;
    logic [4:0] chan_code;
    logic low_off;
    wmasked = 8'h00;
    chan_code = 5'h00;
    low_off = 1'b0;
    nxt_st = st_ff;
    nxt_st.div = st_ff.div + 2'h1;
    nxt_st.rdata = 8'h00;

    if (i_wr_en) begin
      unique case (i_addr)
        `CSC_ADDR_CTRL0: begin
          wmasked = i_wr_data & `CSC_CTRL0_WMASK;
          nxt_st.regs.ctrl0 = wmasked;
        end
        `CSC_ADDR_CHAN: begin
          nxt_st.regs.chan = i_wr_data & `CSC_CHAN_WMASK;
        end
        `CSC_ADDR_COUPLE: begin
          nxt_st.regs.couple = i_wr_data & `CSC_COUPLE_WMASK;
        end
        default: begin
          nxt_st.regs = st_ff.regs;
        end
      endcase
    end

    // Direction reads as sinking while disabled: the oscillator is idle
    nxt_st.direction = osc_level && enable;

    if (i_rd_en) begin
      unique case (i_addr)
        `CSC_ADDR_CTRL0: begin
          nxt_st.rdata = st_ff.regs.ctrl0;
          nxt_st.rdata[`CSC_B_DIR] = st_ff.direction;
        end
        `CSC_ADDR_CHAN: nxt_st.rdata = st_ff.regs.chan;
        `CSC_ADDR_COUPLE: nxt_st.rdata = st_ff.regs.couple;
        `CSC_ADDR_T0: nxt_st.rdata = t0_count;
        `CSC_ADDR_T1L: nxt_st.rdata = t1_count[7:0];
        `CSC_ADDR_T1H: nxt_st.rdata = t1_count[15:8];
        default: nxt_st.rdata = 8'h00;
      endcase
    end

    // Oscillator control follows the registers one cycle after a write
    nxt_st.osc_ctrl.enable = nxt_st.regs.ctrl0[`CSC_B_ENABLE];
    nxt_st.osc_ctrl.high_range = nxt_st.regs.ctrl0[`CSC_B_RANGE];
    nxt_st.osc_ctrl.current =
      nxt_st.regs.ctrl0[`CSC_B_CUR_HI:`CSC_B_CUR_LO];
    low_off = !nxt_st.osc_ctrl.high_range &&
      (nxt_st.osc_ctrl.current == `CSC_CUR_OFF);
    // High range code 00 is noise detection: running, no current
    nxt_st.osc_ctrl.run = nxt_st.osc_ctrl.enable && !low_off;
    nxt_st.osc_ctrl.drive = nxt_st.osc_ctrl.run &&
      (nxt_st.osc_ctrl.current != `CSC_CUR_OFF);

    // Reserved codes select no pin rather than aliasing onto a real one
    chan_code = nxt_st.regs.chan[`CSC_CHAN_HI:0];
    nxt_st.chan_onehot = '0;
    for (int i = 0; i < `CSC_NUM_CHAN; i++) begin
      if (nxt_st.osc_ctrl.enable && (chan_code == 5'(i))) begin
        nxt_st.chan_onehot[i] = 1'b1;
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign o_rd_data = st_ff.rdata;
  assign o_osc_ctrl = st_ff.osc_ctrl;
  assign o_sense_pin_sel = st_ff.chan_onehot;

endmodule

// *** sim/csc_top_monitor.sv ***
// Checker of the capacitive sense control top module.
// Assumes it is bound to csc_top and sees only its ports.
`timescale 1ns/1ps

module csc_top_mon
  import csc_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wr_data,
  input wire logic i_wr_en,
  input wire logic i_rd_en,
  input wire logic i_osc_out,
  input wire logic i_first_timer_clock_pin,
  input wire logic i_second_timer_gate,
  input wire logic i_sleep,
  input wire logic [7:0] o_rd_data,
  input wire csc_osc_ctrl_t o_osc_ctrl,
  input wire logic [16:0] o_sense_pin_sel,
  input wire logic o_first_timer_overflow,
  input wire logic o_second_timer_overflow
);
  // ----------------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------------
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_sys_rst);

  AST_EN_WR: assert property (
    i_wr_en && i_addr == 8'h00 |=> {o_osc_ctrl.enable, o_osc_ctrl.high_range,
      2'b00, o_osc_ctrl.current, 2'b00} == ($past(i_wr_data) & 8'hcc))
    else $error("control write not seen on steering");
  AST_RUN: assert property (
    o_osc_ctrl.run == (o_osc_ctrl.enable &&
      (o_osc_ctrl.high_range || o_osc_ctrl.current != 2'b00)))
    else $error("oscillator run wrong for range and current");
  AST_DRIVE: assert property (
    o_osc_ctrl.drive == (o_osc_ctrl.run && o_osc_ctrl.current != 2'b00))
    else $error("charge current given in noise or off mode");
  AST_PIN_OFF: assert property (
    !o_osc_ctrl.enable |-> o_sense_pin_sel == 17'h0_0000)
    else $error("pin selected while disabled");
  AST_PIN_ONEHOT: assert property ($onehot0(o_sense_pin_sel))
    else $error("more than one sense pin selected");
  AST_CHAN_WR: assert property (
    i_wr_en && i_addr == 8'h01 && o_osc_ctrl.enable &&
      i_wr_data[4:0] <= 5'h10
      |=> o_sense_pin_sel == (17'h0_0001 << ($past(i_wr_data) & 8'h1f)))
    else $error("oscillator not moved to new pin");
  AST_CHAN_RSV: assert property (
    i_wr_en && i_addr == 8'h01 && i_wr_data[4:0] > 5'h10
      |=> o_sense_pin_sel == 17'h0_0000)
    else $error("reserved channel selected a pin");
  AST_RD0_MASK: assert property (
    i_rd_en && i_addr == 8'h00 |=> o_rd_data[5:4] == 2'b00)
    else $error("unused control bits read nonzero");
  AST_RD1_MASK: assert property (
    i_rd_en && i_addr == 8'h01 |=> o_rd_data[7:5] == 3'b000)
    else $error("unused channel bits read nonzero");
  AST_DIR_OFF: assert property (
    i_rd_en && i_addr == 8'h00 && !o_osc_ctrl.enable &&
      !$past(o_osc_ctrl.enable) && !$past(o_osc_ctrl.enable, 2)
      |=> !o_rd_data[1])
    else $error("direction shown while disabled");
  AST_T0_OVF: assert property (
    o_first_timer_overflow |=> !o_first_timer_overflow)
    else $error("first timer overflow longer than one cycle");

  cover property (i_wr_en && i_addr == 8'h01 ##1 o_sense_pin_sel != 0);
  cover property (o_first_timer_overflow);
  cover property (o_second_timer_overflow);
endmodule

bind csc_top csc_top_mon mon_u (
  .i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst), .i_addr(i_addr),
  .i_wr_data(i_wr_data), .i_wr_en(i_wr_en), .i_rd_en(i_rd_en),
  .i_osc_out(i_osc_out), .i_first_timer_clock_pin(i_first_timer_clock_pin),
  .i_second_timer_gate(i_second_timer_gate), .i_sleep(i_sleep),
  .o_rd_data(o_rd_data), .o_osc_ctrl(o_osc_ctrl),
  .o_sense_pin_sel(o_sense_pin_sel),
  .o_first_timer_overflow(o_first_timer_overflow),
  .o_second_timer_overflow(o_second_timer_overflow));

// *** sim/csc_pad_model.sv ***
// Touch pad with its relaxation oscillator as seen at the sense pin.
// Assumes the steering struct of the sense block and the bench clock.
`timescale 1ns/1ps

module csc_pad_model
  import csc_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  input wire csc_osc_ctrl_t i_osc_ctrl,
  input wire logic [7:0] i_half,
  output logic o_osc
);
  int ph;

  // A high phase always runs to its end, so no runt pulse reaches the pin
  always @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      ph <= 0;
      o_osc <= 1'b0;
    end else if (i_osc_ctrl.drive || o_osc) begin
      ph <= (ph + 1 >= i_half) ? 0 : ph + 1;
      if (ph + 1 >= i_half) o_osc <= ~o_osc;
    end else begin
      ph <= 0;
    end
  end
endmodule

// *** sim/test_capacitive_sense_control.sv ***
// Self-checking bench of the capacitive sense control block.
// Assumes csc_top, csc_pad_model and the checker bind are compiled first.
`timescale 1ns/1ps

module test_capacitive_sense_control
  import csc_pkg::*;
;
  logic i_ref_clk = 1'b0, i_sys_rst = 1'b1, wr_en = 1'b0, rd_en = 1'b0;
  logic osc, pin = 1'b0, pin_q = 1'b0, osc_q = 1'b0, gate = 1'b0;
  logic sleep = 1'b0, pin_go = 1'b0, ovf0, ovf1;
  logic [7:0] addr = 8'h00, wdata = 8'h00, half = 8'h05, rd_data, rdata;
  logic [7:0] m_reg [0:2];
  logic [15:0] rv;
  logic [16:0] pin_sel;
  logic [31:0] seed = 32'h0001_6db6;
  csc_osc_ctrl_t osc_ctrl;
  int fails = 0, checks = 0, n_osc = 0, n_pin = 0, pc = 0, c_nom;

  always #5 i_ref_clk = ~i_ref_clk;

  csc_top dut_u (.i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst),
    .i_addr(addr), .i_wr_data(wdata), .i_wr_en(wr_en), .i_rd_en(rd_en),
    .i_osc_out(osc), .i_first_timer_clock_pin(pin),
    .i_second_timer_gate(gate), .i_sleep(sleep), .o_rd_data(rd_data),
    .o_osc_ctrl(osc_ctrl), .o_sense_pin_sel(pin_sel),
    .o_first_timer_overflow(ovf0), .o_second_timer_overflow(ovf1));
  csc_pad_model pad_u (.i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst),
    .i_osc_ctrl(osc_ctrl), .i_half(half), .o_osc(osc));

  // ----------------------------------------------------------------------
  // Clock pin source and edge counting of both sources
  // ----------------------------------------------------------------------
  always @(posedge i_ref_clk) begin
    osc_q <= osc;
    pin_q <= pin;
    if (osc && !osc_q) n_osc <= n_osc + 1;
    if (pin && !pin_q) n_pin <= n_pin + 1;
    if (pin_go || pin) pc <= pc + 1;
    if ((pin_go || pin) && pc % 4 == 3) pin <= ~pin;
  end

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic tally_and_finish();
    if (fails == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [16:0] seen,
                     input logic [16:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_ref_clk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge i_ref_clk);
    wr_en <= 1'b0;
    #1;
    case (a)
      8'h00: m_reg[0] = d & 8'hcd;
      8'h01: m_reg[1] = d & 8'h1f;
      8'h02: m_reg[2] = d & 8'h37;
      default: ;
    endcase
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge i_ref_clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge i_ref_clk);
    rd_en <= 1'b0;
    #1 rdata = rd_data;
  endtask

  task automatic t1();
    rd(8'h04);
    rv[7:0] = rdata;
    rd(8'h05);
    rv[15:8] = rdata;
  endtask

  // Direction bit follows the live oscillator while enabled, so it is masked
  task automatic rchk(input logic [7:0] a);
    rd(a);
    chk("register", rdata & ((a == 8'h00 && m_reg[0][7]) ? 8'hfd : 8'hff),
        (a < 8'h03) ? m_reg[a] : 8'h00);
  endtask

  task automatic ochk();
    logic [7:0] c;
    c = m_reg[0];
    chk("osc_ctrl", osc_ctrl, {c[7], c[6], c[3:2], c[7] && (c[6] ||
        c[3:2] != 2'b00), c[7] && c[3:2] != 2'b00});
    chk("pin_sel", pin_sel, (c[7] && m_reg[1] <= 8'h10) ?
        17'h0_0001 << m_reg[1] : 17'h0_0000);
  endtask

  // Sources stopped at window end; long tail lets the last phase pass the sync
  task automatic window(input logic [7:0] c0, input int n);
    wr(8'h00, c0);
    n_osc = 0;
    n_pin = 0;
    pin_go = 1'b1;
    repeat (n) @(posedge i_ref_clk);
    pin_go <= 1'b0;
    wr(8'h00, c0 & 8'hf3);
    repeat (16) @(posedge i_ref_clk);
  endtask

  task automatic wait_ovf(input bit which);
    bit seen;
    seen = 1'b0;
    for (int i = 0; i < 300 && !seen; i++) begin
      @(posedge i_ref_clk);
      #1 seen = which ? ovf1 : ovf0;
    end
    chk("overflow", seen, 1'b1);
    if (!seen) tally_and_finish();
  endtask

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    logic [31:0] r;
    logic [7:0] a;
    for (int i = 0; i < 3; i++) m_reg[i] = 8'h00;
    repeat (10) @(posedge i_ref_clk);
    i_sys_rst <= 1'b0;
    // The first timer runs from the divided clock out of reset
    for (int i = 0; i < 8; i++) begin
      if (i != 3) rchk(i[7:0]);
      else begin
        rd(8'h03);
        chk("t0_reset", rdata <= 8'h03, 1'b1);
      end
    end
    for (int i = 0; i < 24; i++) begin
      r = xs();
      a = (r[1:0] == 2'b11) ? 8'h30 : {6'h00, r[1:0]};
      wr(a, r[15:8]);
      rchk(a);
      ochk();
    end
    wr(8'h00, 8'h80);
    for (int k = 0; k < 32; k++) begin
      wr(8'h01, k[7:0]);
      ochk();
    end
    for (int k = 0; k < 16; k++) begin
      wr(8'h00, {k[3], k[2], 2'b00, k[1:0], 2'b00});
      ochk();
    end
    wr(8'h00, 8'h80);
    repeat (16) @(posedge i_ref_clk);
    sleep <= 1'b1;
    for (int k = 0; k < 8; k++) begin
      gate <= k[2];
      wr(8'h02, {4'h3, 1'b0, k[1], k[0], 1'b0});
      wr(8'h04, 8'h00);
      wr(8'h05, 8'h00);
      window(8'h8c, 120);
      t1();
      chk("second_timer", rv, (k[0] && (!k[1] || k[2])) ? n_osc : 0);
    end
    c_nom = rv;
    half = 8'h08;
    wr(8'h04, 8'h00);
    wr(8'h05, 8'h00);
    window(8'h8c, 120);
    t1();
    chk("loaded", rv, n_osc[15:0]);
    chk("loaded_lower", rv < c_nom, 1'b1);
    chk("threshold", c_nom > (c_nom + rv) / 2, 1'b1);
    half = 8'h05;
    sleep <= 1'b0;
    wr(8'h02, 8'h00);
    wr(8'h03, 8'h00);
    repeat (40) @(posedge i_ref_clk);
    rd(8'h03);
    chk("t0_div4", rdata >= 8'h09 && rdata <= 8'h0b, 1'b1);
    sleep <= 1'b1;
    wr(8'h03, 8'h00);
    repeat (40) @(posedge i_ref_clk);
    rd(8'h03);
    chk("t0_sleep", rdata, 8'h00);
    sleep <= 1'b0;
    wr(8'h02, 8'h01);
    wr(8'h03, 8'h00);
    window(8'h8d, 100);
    rd(8'h03);
    chk("t0_osc", rdata, n_osc[7:0]);
    wr(8'h03, 8'h00);
    window(8'h8c, 100);
    rd(8'h03);
    chk("t0_pin", rdata, n_pin[7:0]);
    wr(8'h02, 8'h00);
    wr(8'h03, 8'hfe);
    wait_ovf(1'b0);
    wr(8'h02, 8'h12);
    wr(8'h05, 8'hff);
    wr(8'h04, 8'hff);
    wait_ovf(1'b1);
    wr(8'h02, 8'h22);
    wr(8'h04, 8'h00);
    wr(8'h05, 8'h00);
    repeat (20) @(posedge i_ref_clk);
    t1();
    chk("t1_none", rv, 16'h0000);
    tally_and_finish();
  end
endmodule
